// ---- hdl/cas_alu_status.v ----
// cpu integer alu, multiplier, divider, status word and core config word
// Functional notes
// [RULE1] half carry from bit four or eight
// [RULE2] level is msb over low bits, blocks interrupts
// [RULE3] low level bits frozen under nesting disable
// [RULE4] repeat active bit reads running repeat
// [RULE5] negative flag follows result sign
// [RULE6] overflow flag marks signed sign error
// [RULE7] zero flag sticky set, nonzero clears; code loads the zero flag from every result whose alu_flag_mask bit 1 is set
// [RULE8] carry flag from result msb
// [RULE9] subtraction carries mean borrow instead
// [RULE10] unsigned multiply select bit
// [RULE11] early exit write ends loop, reads zero
// [RULE12] loop nest depth reports zero to seven
// [RULE13] accumulator a and b clamp enables
// [RULE14] store clamp enable resets to one
// [RULE15] clamp width select super or normal
// [RULE16] priority msb readable, clearable, not settable
// [RULE17] program window enable bit
// [RULE18] round bias select bit
// [RULE19] integer or fractional multiply select
// [RULE20] byte or word add, sub, shift, logic
// [RULE21] multiplier supports all listed sign modes
// [RULE22] iterative divider, quotient w0, remainder w1
// [RULE23] decoder issues divide inside repeat loop
// [RULE24] flags update with writeback, others hold
`timescale 1ns/1ps
`include "cas_map.vh"

module cas_alu_status (
	// clock and reset
	input wire sys_clk,
	input wire nrst,
	// register port
	input wire [1:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	// alu request from the decoder
	input wire alu_go,
	input wire [3:0] alu_op,
	input wire alu_byte,
	input wire alu_use_carry,
	input wire [15:0] alu_a,
	input wire [15:0] alu_b,
	input wire [4:0] alu_flag_mask,
	output reg [15:0] alu_result,
	output reg alu_done,
	// multiplier
	input wire mul_go,
	input wire [2:0] mul_mode,
	input wire [15:0] mul_a,
	input wire [15:0] mul_b,
	output reg [31:0] mul_result,
	output reg mul_done,
	// divider
	input wire div_go,
	input wire div_signed,
	input wire div_long,
	input wire [31:0] div_dividend,
	input wire [15:0] div_divisor,
	output reg [15:0] div_w0,
	output reg [15:0] div_w1,
	output reg div_done,
	output wire div_busy,
	// loop and priority inputs from the core
	input wire repeat_running,
	input wire do_running,
	input wire [2:0] do_depth,
	input wire nesting_disable,
	input wire level_load,
	input wire [3:0] level_value,
	// control outputs
	output wire [3:0] cpu_level,
	output wire user_irq_block,
	output reg early_loop_exit,
	output wire unsigned_multiply,
	output wire acc_a_clamp_enable,
	output wire acc_b_clamp_enable,
	output wire store_clamp_enable,
	output wire clamp_width_select,
	output wire program_window_enable,
	output wire round_bias_select,
	output wire integer_multiply
);

	////////////////////////////////////////////////////////////////////////////////
	// state
	reg [2:0] priority_level_low;
	reg priority_level_msb;
	reg half_carry_flag, neg_flag, ovf_flag, zero_flag, carry_flag;
	reg [7:0] cfg_bits;
	reg [31:0] div_rem_q;
	reg [16:0] div_acc;
	reg [4:0] div_cnt;
	reg div_neg_q, div_neg_r;
	reg [15:0] div_dvs;

	////////////////////////////////////////////////////////////////////////////////
	// alu combinational result and flags
	reg [16:0] sum_w;
	reg [8:0] sum_lo;
	reg [4:0] sum_nib;
	reg [15:0] res;
	reg f_c, f_dc, f_ov, f_n, f_z, sgn_a, sgn_b, sgn_r;
	wire cin = alu_use_carry ? carry_flag : (alu_op == `CAS_OP_SUB);
	wire [15:0] b_eff = (alu_op == `CAS_OP_SUB) ? ~alu_b : alu_b; // borrow via complement
	always @* begin
		sum_w = {1'b0, alu_a} + {1'b0, b_eff} + {16'h0000, cin};
		sum_lo = {1'b0, alu_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, cin};
		sum_nib = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
		res = sum_w[15:0];
		f_c = alu_byte ? sum_lo[8] : sum_w[16]; // RULE8 RULE9
		f_dc = alu_byte ? sum_nib[4] : sum_lo[8]; // RULE1 RULE9
		case (alu_op)
			`CAS_OP_ADD, `CAS_OP_SUB: res = sum_w[15:0]; // RULE20
			`CAS_OP_AND: res = alu_a & alu_b;
			`CAS_OP_OR: res = alu_a | alu_b;
			`CAS_OP_XOR: res = alu_a ^ alu_b;
			`CAS_OP_SHL: begin
				res = {alu_a[14:0], 1'b0};
				f_c = alu_byte ? alu_a[7] : alu_a[15];
			end
			`CAS_OP_SHR: begin
				res = {1'b0, alu_a[15:1]};
				if (alu_byte)
					res[7] = 1'b0;
				f_c = alu_a[0];
			end
			`CAS_OP_ASR: begin
				res = {alu_a[15], alu_a[15:1]};
				if (alu_byte)
					res[7] = alu_a[7];
				f_c = alu_a[0];
			end
			default: res = sum_w[15:0];
		endcase
		if (alu_byte)
			res[15:8] = alu_a[15:8]; // byte ops leave the upper byte
		sgn_a = alu_byte ? alu_a[7] : alu_a[15];
		sgn_b = alu_byte ? b_eff[7] : b_eff[15];
		sgn_r = alu_byte ? res[7] : res[15];
		f_n = sgn_r; // RULE5
		f_ov = (alu_op == `CAS_OP_ADD || alu_op == `CAS_OP_SUB) &&
			(sgn_a == sgn_b) && (sgn_r != sgn_a); // RULE6
		f_z = alu_byte ? (res[7:0] == 8'h00) : (res == 16'h0000);
	end

	////////////////////////////////////////////////////////////////////////////////
	// alu writeback and flag update, mask order is c z ov n dc
	wire st_wr = reg_wr && (reg_addr == `CAS_ADDR_STATUS);
	wire cc_wr = reg_wr && (reg_addr == `CAS_ADDR_CONFIG);
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			alu_result <= 16'h0000;
			alu_done <= 1'b0;
			carry_flag <= 1'b0;
			zero_flag <= 1'b0;
			ovf_flag <= 1'b0;
			neg_flag <= 1'b0;
			half_carry_flag <= 1'b0;
		end else begin
			alu_done <= alu_go;
			if (st_wr) begin
				carry_flag <= reg_wdata[`CAS_ST_C];
				zero_flag <= reg_wdata[`CAS_ST_Z];
				ovf_flag <= reg_wdata[`CAS_ST_OV];
				neg_flag <= reg_wdata[`CAS_ST_N];
				half_carry_flag <= reg_wdata[`CAS_ST_HC];
			end
			if (alu_go) begin
				alu_result <= res;
				if (alu_flag_mask[0])
					carry_flag <= f_c; // RULE24
				if (alu_flag_mask[1])
					zero_flag <= f_z; // RULE7
				if (alu_flag_mask[2])
					ovf_flag <= f_ov;
				if (alu_flag_mask[3])
					neg_flag <= f_n;
				if (alu_flag_mask[4])
					half_carry_flag <= f_dc;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// priority level, hardware load wins over software
	assign cpu_level = {priority_level_msb, priority_level_low}; // RULE2
	assign user_irq_block = priority_level_msb || (priority_level_low == `CAS_LEVEL_MAX); // RULE2
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			priority_level_low <= 3'h0;
			priority_level_msb <= 1'b0;
		end else if (level_load) begin
			priority_level_low <= level_value[2:0];
			priority_level_msb <= level_value[3];
		end else begin
			if (st_wr && !nesting_disable)
				priority_level_low <= reg_wdata[`CAS_ST_LVL_HI:`CAS_ST_LVL_LO]; // RULE3
			if (cc_wr && !reg_wdata[`CAS_CC_LVL_MSB])
				priority_level_msb <= 1'b0; // RULE16
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// config bits, early exit is a one-cycle pulse
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cfg_bits <= `CAS_CC_RESET_LOW;
			early_loop_exit <= 1'b0;
		end else begin
			early_loop_exit <= cc_wr && reg_wdata[`CAS_CC_EXIT]; // RULE11
			if (cc_wr) begin
				cfg_bits[`CAS_CC_IF] <= reg_wdata[`CAS_CC_IF]; // RULE19
				cfg_bits[`CAS_CC_RBIAS] <= reg_wdata[`CAS_CC_RBIAS]; // RULE18
				cfg_bits[`CAS_CC_PWIN] <= reg_wdata[`CAS_CC_PWIN]; // RULE17
				cfg_bits[`CAS_CC_CLW] <= reg_wdata[`CAS_CC_CLW]; // RULE15
				cfg_bits[`CAS_CC_STCL] <= reg_wdata[`CAS_CC_STCL]; // RULE14
				cfg_bits[`CAS_CC_CLB] <= reg_wdata[`CAS_CC_CLB]; // RULE13
				cfg_bits[`CAS_CC_CLA] <= reg_wdata[`CAS_CC_CLA]; // RULE13
				cfg_bits[`CAS_CC_LVL_MSB] <= 1'b0;
			end
		end
	end
	reg umul_bit;
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			umul_bit <= 1'b0;
		else if (cc_wr)
			umul_bit <= reg_wdata[`CAS_CC_UMUL]; // RULE10
	end
	assign unsigned_multiply = umul_bit;
	assign integer_multiply = cfg_bits[`CAS_CC_IF];
	assign round_bias_select = cfg_bits[`CAS_CC_RBIAS];
	assign program_window_enable = cfg_bits[`CAS_CC_PWIN];
	assign clamp_width_select = cfg_bits[`CAS_CC_CLW];
	assign store_clamp_enable = cfg_bits[`CAS_CC_STCL];
	assign acc_b_clamp_enable = cfg_bits[`CAS_CC_CLB];
	assign acc_a_clamp_enable = cfg_bits[`CAS_CC_CLA];

	////////////////////////////////////////////////////////////////////////////////
	// register read, data one cycle after the strobe
	reg [15:0] st_view, cc_view;
	always @* begin
		st_view = 16'h0000;
		st_view[`CAS_ST_C] = carry_flag;
		st_view[`CAS_ST_Z] = zero_flag;
		st_view[`CAS_ST_OV] = ovf_flag;
		st_view[`CAS_ST_N] = neg_flag;
		st_view[`CAS_ST_REP] = repeat_running; // RULE4
		st_view[`CAS_ST_LVL_HI:`CAS_ST_LVL_LO] = priority_level_low;
		st_view[`CAS_ST_HC] = half_carry_flag;
		st_view[`CAS_ST_DO] = do_running;
		cc_view = {8'h00, cfg_bits};
		cc_view[`CAS_CC_LVL_MSB] = priority_level_msb; // RULE16
		cc_view[`CAS_CC_NEST_HI:`CAS_CC_NEST_LO] = do_depth; // RULE12
		cc_view[`CAS_CC_EXIT] = 1'b0; // RULE11
		cc_view[`CAS_CC_UMUL] = umul_bit;
	end
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			reg_rdata <= 16'h0000;
		else if (reg_rd) begin
			case (reg_addr)
				`CAS_ADDR_STATUS: reg_rdata <= st_view;
				`CAS_ADDR_CONFIG: reg_rdata <= cc_view;
				`CAS_ADDR_EFFLVL: reg_rdata <= {12'h000, cpu_level};
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// multiplier, 17x17 with per-mode extension
	reg [16:0] ma, mb;
	always @* begin
		ma = {1'b0, mul_a};
		mb = {1'b0, mul_b};
		case (mul_mode) // RULE21
			`CAS_MUL_SS: begin
				ma = {mul_a[15], mul_a};
				mb = {mul_b[15], mul_b};
			end
			`CAS_MUL_UU: ma = {1'b0, mul_a};
			`CAS_MUL_SU: ma = {mul_a[15], mul_a};
			`CAS_MUL_UXS: mb = {mul_b[15], mul_b};
			`CAS_MUL_SL: begin
				ma = {mul_a[15], mul_a};
				mb = {12'h000, mul_b[4:0]};
			end
			`CAS_MUL_UL: mb = {12'h000, mul_b[4:0]};
			`CAS_MUL_B8: begin
				ma = {9'h000, mul_a[7:0]};
				mb = {9'h000, mul_b[7:0]};
			end
			default: ma = {1'b0, mul_a};
		endcase
	end
	wire signed [33:0] prod = $signed(ma) * $signed(mb);
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mul_result <= 32'h0000_0000;
			mul_done <= 1'b0;
		end else begin
			mul_done <= mul_go;
			if (mul_go)
				mul_result <= prod[31:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// restoring divider, one step per divisor bit on magnitudes
	wire [31:0] dvd_in = div_long ? div_dividend : {{16{div_signed & div_dividend[15]}},
		div_dividend[15:0]};
	wire dvd_neg = div_signed && dvd_in[31];
	wire dvs_neg = div_signed && div_divisor[15];
	wire [31:0] dvd_mag = dvd_neg ? (~dvd_in + 32'h0000_0001) : dvd_in;
	wire [15:0] dvs_mag = dvs_neg ? (~div_divisor + 16'h0001) : div_divisor;
	// one spare bit keeps a true borrow apart from a shifted-out partial remainder bit
	wire [17:0] trial = {1'b0, div_acc[15:0], div_rem_q[31]} - {2'b00, div_dvs};
	assign div_busy = (div_cnt != 5'h00);
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt <= 5'h00;
			div_acc <= 17'h0_0000;
			div_rem_q <= 32'h0000_0000;
			div_dvs <= 16'h0000;
			div_neg_q <= 1'b0;
			div_neg_r <= 1'b0;
			div_w0 <= 16'h0000;
			div_w1 <= 16'h0000;
			div_done <= 1'b0;
		end else begin
			div_done <= 1'b0;
			if (div_go && !div_busy) begin
				div_cnt <= `CAS_DIV_STEPS;
				div_acc <= {1'b0, dvd_mag[31:16]}; // high half is zero in short mode
				div_rem_q <= {dvd_mag[15:0], 16'h0000};
				div_dvs <= dvs_mag;
				div_neg_q <= dvd_neg ^ dvs_neg;
				div_neg_r <= dvd_neg;
			end else if (div_busy) begin
				div_cnt <= div_cnt - 5'h01; // RULE22
				div_rem_q <= {div_rem_q[30:0], ~trial[17]};
				div_acc <= trial[17] ? {div_acc[15:0], div_rem_q[31]} : trial[16:0];
				if (div_cnt == 5'h01)
					div_done <= 1'b1;
			end
			if (div_done) begin
				div_w0 <= div_neg_q ? (~div_rem_q[15:0] + 16'h0001) : div_rem_q[15:0]; // RULE22
				div_w1 <= div_neg_r ? (~div_acc[15:0] + 16'h0001) : div_acc[15:0];
			end
		end
	end

endmodule

// ---- hdl/cas_map.vh ----
// constants for the cpu alu, status word and core config word
`ifndef CAS_MAP_VH
`define CAS_MAP_VH
// register addresses on the plain port
`define CAS_ADDR_STATUS 2'h0
`define CAS_ADDR_CONFIG 2'h1
`define CAS_ADDR_EFFLVL 2'h2
// status word fields
`define CAS_ST_C 0
`define CAS_ST_Z 1
`define CAS_ST_OV 2
`define CAS_ST_N 3
`define CAS_ST_REP 4
`define CAS_ST_LVL_LO 5
`define CAS_ST_LVL_HI 7
`define CAS_ST_HC 8
`define CAS_ST_DO 9
// config word fields
`define CAS_CC_IF 0
`define CAS_CC_RBIAS 1
`define CAS_CC_PWIN 2
`define CAS_CC_LVL_MSB 3
`define CAS_CC_CLW 4
`define CAS_CC_STCL 5
`define CAS_CC_CLB 6
`define CAS_CC_CLA 7
`define CAS_CC_NEST_LO 8
`define CAS_CC_NEST_HI 10
`define CAS_CC_EXIT 11
`define CAS_CC_UMUL 12
// reset values
`define CAS_ST_RESET 16'h0000
`define CAS_CC_RESET 16'h0020
`define CAS_CC_RESET_LOW 8'h20
// alu operation codes
`define CAS_OP_ADD 4'h0
`define CAS_OP_SUB 4'h1
`define CAS_OP_AND 4'h2
`define CAS_OP_OR 4'h3
`define CAS_OP_XOR 4'h4
`define CAS_OP_SHL 4'h5
`define CAS_OP_SHR 4'h6
`define CAS_OP_ASR 4'h7
// multiply modes
`define CAS_MUL_SS 3'h0
`define CAS_MUL_UU 3'h1
`define CAS_MUL_SU 3'h2
`define CAS_MUL_UXS 3'h3
`define CAS_MUL_SL 3'h4
`define CAS_MUL_UL 3'h5
`define CAS_MUL_B8 3'h6
// divider step count and top priority level
`define CAS_DIV_STEPS 5'h10
`define CAS_LEVEL_MAX 3'h7
`endif

// ---- sim/cas_checker.sv ----
// assertion checker for the cpu alu and status block
`timescale 1ns/1ps
`include "cas_map.vh"
module cas_checker (
	// clock and reset
	input wire sys_clk,
	input wire nrst,
	// register port
	input wire [1:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_rdata,
	// alu and multiplier
	input wire alu_go,
	input wire [3:0] alu_op,
	input wire alu_byte,
	input wire alu_use_carry,
	input wire [15:0] alu_a,
	input wire [15:0] alu_b,
	input wire [15:0] alu_result,
	input wire alu_done,
	input wire mul_go,
	input wire [2:0] mul_mode,
	input wire [15:0] mul_a,
	input wire [15:0] mul_b,
	input wire [31:0] mul_result,
	// divider
	input wire div_go,
	input wire div_busy,
	input wire div_done,
	// loop and level
	input wire repeat_running,
	input wire [2:0] do_depth,
	input wire level_load,
	input wire [3:0] level_value,
	input wire [3:0] cpu_level,
	input wire user_irq_block,
	input wire early_loop_exit
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// divide steps: busy run, then the done pulse
	sequence s_div_run;
		div_busy [*8];
	endsequence
	sequence s_div_end;
		div_done && !div_busy;
	endsequence
	property p_div;
		div_go && !div_busy |=> s_div_run ##1 s_div_run ##1 s_div_end;
	endproperty
	a_div: assert property (p_div) else $error("divide timing wrong");
	property p_alu_done;
		alu_go |=> alu_done;
	endproperty
	a_alu_done: assert property (p_alu_done) else $error("alu done missing");
	property p_add;
		alu_go && alu_op == `CAS_OP_ADD && !alu_byte && !alu_use_carry
		|=> alu_result == $past(alu_a) + $past(alu_b);
	endproperty
	a_add: assert property (p_add) else $error("word add wrong");
	property p_mul_uu;
		mul_go && mul_mode == `CAS_MUL_UU
		|=> mul_result == {16'h0000, $past(mul_a)} * {16'h0000, $past(mul_b)};
	endproperty
	a_mul_uu: assert property (p_mul_uu) else $error("unsigned product wrong");
	property p_mul_ss;
		mul_go && mul_mode == `CAS_MUL_SS
		|=> $signed(mul_result) == $signed($past(mul_a)) * $signed($past(mul_b));
	endproperty
	a_mul_ss: assert property (p_mul_ss) else $error("signed product wrong");
	property p_lvl;
		level_load |=> cpu_level == $past(level_value);
	endproperty
	a_lvl: assert property (p_lvl) else $error("level load lost");
	property p_blk;
		user_irq_block == (cpu_level[3] | (&cpu_level[2:0]));
	endproperty
	a_blk: assert property (p_blk) else $error("irq block wrong");
	property p_edt;
		early_loop_exit |-> $past(reg_wr && reg_addr == `CAS_ADDR_CONFIG && reg_wdata[`CAS_CC_EXIT]);
	endproperty
	a_edt: assert property (p_edt) else $error("loop exit without write");
	property p_cfg_rd;
		reg_rd && reg_addr == `CAS_ADDR_CONFIG
		|=> reg_rdata[`CAS_CC_EXIT] == 1'h0 &&
		reg_rdata[`CAS_CC_NEST_HI:`CAS_CC_NEST_LO] == $past(do_depth);
	endproperty
	a_cfg_rd: assert property (p_cfg_rd) else $error("config read wrong");
	property p_ra;
		reg_rd && reg_addr == `CAS_ADDR_STATUS |=> reg_rdata[`CAS_ST_REP] == $past(repeat_running);
	endproperty
	a_ra: assert property (p_ra) else $error("repeat bit wrong");
endmodule
bind cas_alu_status cas_checker chk_u (.*);

// ---- sim/cas_decoder_model.sv ----
// decoder model that issues divides inside a repeat loop
`timescale 1ns/1ps
module cas_decoder_model (
	// clock and reset
	input wire sys_clk,
	input wire nrst,
	// command from the bench
	input wire start,
	input wire [31:0] dvd,
	input wire [15:0] dvs,
	output reg fin,
	// divider side of the block
	output reg div_go,
	output reg [31:0] div_dividend,
	output reg [15:0] div_divisor,
	output reg repeat_running,
	input wire div_busy,
	input wire div_done
);
	reg tail;
	// hold operands through the loop, scramble them once it ends
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			div_go <= 1'h0;
			repeat_running <= 1'h0;
			fin <= 1'h0;
			tail <= 1'h0;
			div_dividend <= 32'h0000_0000;
			div_divisor <= 16'h0000;
		end else begin
			div_go <= 1'h0;
			fin <= 1'h0;
			tail <= div_done;
			if (start && !repeat_running && !div_busy) begin
				repeat_running <= 1'h1;
				div_go <= 1'h1;
				div_dividend <= dvd;
				div_divisor <= dvs;
			end
			if (tail) begin
				repeat_running <= 1'h0;
				fin <= 1'h1;
				div_dividend <= ~div_dividend;
				div_divisor <= ~div_divisor;
			end
		end
	end
endmodule

// ---- sim/cpu_alu_status_control_bench.sv ----
// self-checking bench for the cpu alu and status block
`timescale 1ns/1ps
`include "cas_map.vh"
module cpu_alu_status_control_bench;
	reg sys_clk, nrst, reg_wr, reg_rd, alu_go, alu_byte, alu_use_carry, mul_go;
	reg div_signed, div_long, start, do_running, nesting_disable, level_load;
	reg [1:0] reg_addr;
	reg [15:0] reg_wdata, alu_a, alu_b, mul_a, mul_b, dvs;
	reg [3:0] alu_op, level_value;
	reg [4:0] alu_flag_mask;
	reg [2:0] mul_mode, do_depth;
	reg [31:0] dvd;
	reg [31:0] mexp [0:6];
	wire [15:0] reg_rdata, alu_result, div_w0, div_w1, div_divisor;
	wire [31:0] mul_result, div_dividend;
	wire [3:0] cpu_level;
	wire alu_done, mul_done, div_done, div_busy, div_go, repeat_running, fin;
	wire user_irq_block, early_loop_exit, unsigned_multiply, acc_a_clamp_enable;
	wire acc_b_clamp_enable, store_clamp_enable, clamp_width_select;
	wire program_window_enable, round_bias_select, integer_multiply;
	wire [7:0] cfg_out;
	integer mismatches, samples_checked, cyc, k;
	assign cfg_out = {unsigned_multiply, acc_a_clamp_enable, acc_b_clamp_enable,
		store_clamp_enable, clamp_width_select, program_window_enable,
		round_bias_select, integer_multiply};
	cas_alu_status dut_u (.*);
	cas_decoder_model dec_u (.*);
	////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial begin
		sys_clk = 1'h0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			mismatches = mismatches + 1;
			end_sim;
		end
	end
	// compare and count
	task chk(input [23:0] nm, input [31:0] s, input [31:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (s !== e) begin
				mismatches = mismatches + 1;
				$display("CHECK FAILED %s exp %h seen %h", nm, e, s);
			end
		end
	endtask
	task end_sim;
		begin
			if (mismatches == 0 && samples_checked > 0) begin
				$display("TEST PASSED");
			end else begin
				$display("TEST FAILED");
			end
			$finish;
		end
	endtask
	// register port cycles
	task wr(input [1:0] a, input [15:0] d);
		begin
			@(posedge sys_clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'h1;
			@(posedge sys_clk);
			reg_wr <= 1'h0;
		end
	endtask
	task rd(input [1:0] a, input [15:0] m, input [15:0] e);
		begin
			@(posedge sys_clk);
			reg_addr <= a;
			reg_rd <= 1'h1;
			@(posedge sys_clk);
			reg_rd <= 1'h0;
			#1 chk("reg", reg_rdata & m, e);
		end
	endtask
	task alu(input [3:0] op, input by, input [15:0] a, input [15:0] b, input [4:0] m,
		input [15:0] e);
		begin
			@(posedge sys_clk);
			alu_op <= op;
			alu_byte <= by;
			alu_a <= a;
			alu_b <= b;
			alu_flag_mask <= m;
			alu_go <= 1'h1;
			@(posedge sys_clk);
			alu_go <= 1'h0;
			#1 chk("alu", alu_result, e);
		end
	endtask
	task dv(input s, input l, input [31:0] n, input [15:0] d, input [15:0] q,
		input [15:0] r);
		begin
			@(posedge sys_clk);
			div_signed <= s;
			div_long <= l;
			dvd <= n;
			dvs <= d;
			start <= 1'h1;
			@(posedge sys_clk);
			start <= 1'h0;
			rd(`CAS_ADDR_STATUS, 16'h0010, 16'h0010);
			for (k = 0; k < 40 && fin !== 1'h1; k = k + 1) @(posedge sys_clk) #1;
			chk("quo", div_w0, q);
			chk("rem", div_w1, r);
			rd(`CAS_ADDR_STATUS, 16'h0010, 16'h0000);
		end
	endtask
	task lvl(input [3:0] v);
		begin
			@(posedge sys_clk);
			level_value <= v;
			level_load <= 1'h1;
			@(posedge sys_clk);
			level_load <= 1'h0;
		end
	endtask
	// main sequence
	initial begin
		{mismatches, samples_checked, cyc} = 0;
		{nrst, reg_wr, reg_rd, alu_go, alu_byte, alu_use_carry, mul_go} = 0;
		{div_signed, div_long, start, do_running, nesting_disable, level_load} = 0;
		{reg_addr, reg_wdata, alu_a, alu_b, mul_a, mul_b, dvs, dvd} = 0;
		{alu_op, level_value, alu_flag_mask, mul_mode, do_depth} = 0;
		mexp[0] = 32'h0000_003A;
		mexp[1] = 32'hFFE1_003A;
		mexp[2] = 32'hFFFE_003A;
		mexp[3] = 32'hFFE3_003A;
		mexp[4] = 32'hFFFF_FFFA;
		mexp[5] = 32'h0002_FFFA;
		mexp[6] = 32'h0000_E13A;
		repeat (12) @(posedge sys_clk);
		nrst <= 1'h1;
		rd(`CAS_ADDR_STATUS, 16'hFFFF, 16'h0000);
		rd(`CAS_ADDR_CONFIG, 16'hFFFF, 16'h0020);
		chk("cfg", cfg_out, 8'h10);
		do_depth <= 3'h7;
		do_running <= 1'h1;
		wr(`CAS_ADDR_CONFIG, 16'hFFFF);
		#1 chk("edt", early_loop_exit, 1'h1);
		rd(`CAS_ADDR_CONFIG, 16'hFFFF, 16'h17F7);
		chk("cfg", cfg_out, 8'hFF);
		wr(`CAS_ADDR_CONFIG, 16'h0000);
		#1 chk("cfg", cfg_out, 8'h00);
		wr(`CAS_ADDR_CONFIG, 16'h10A5);
		#1 chk("cfg", cfg_out, 8'hD5);
		lvl(4'hF);
		#1 chk("lvl", {user_irq_block, cpu_level}, 5'h1F);
		rd(`CAS_ADDR_CONFIG, 16'h0008, 16'h0008);
		wr(`CAS_ADDR_CONFIG, 16'h0000);
		wr(`CAS_ADDR_CONFIG, 16'h0008);
		#1 chk("lvl", {user_irq_block, cpu_level}, 5'h17);
		lvl(4'h3);
		#1 chk("lvl", {user_irq_block, cpu_level}, 5'h03);
		nesting_disable <= 1'h1;
		wr(`CAS_ADDR_STATUS, 16'h02F0);
		rd(2'h2, 16'h000F, 16'h0003);
		rd(`CAS_ADDR_STATUS, 16'h0210, 16'h0200);
		nesting_disable <= 1'h0;
		wr(`CAS_ADDR_STATUS, 16'h00E0);
		rd(2'h2, 16'h000F, 16'h0007);
		alu(`CAS_OP_ADD, 1'h0, 16'h7FFF, 16'h0001, 5'h1F, 16'h8000);
		rd(`CAS_ADDR_STATUS, 16'h010F, 16'h010C);
		alu(`CAS_OP_SUB, 1'h0, 16'h0005, 16'h0005, 5'h1F, 16'h0000);
		rd(`CAS_ADDR_STATUS, 16'h010F, 16'h0103);
		alu(`CAS_OP_AND, 1'h0, 16'h0F0F, 16'h00FF, 5'h08, 16'h000F);
		rd(`CAS_ADDR_STATUS, 16'h010F, 16'h0103);
		alu_use_carry <= 1'h1;
		alu(`CAS_OP_ADD, 1'h0, 16'h0001, 16'h0001, 5'h1F, 16'h0003);
		alu_use_carry <= 1'h0;
		rd(`CAS_ADDR_STATUS, 16'h010F, 16'h0000);
		alu(`CAS_OP_SUB, 1'h0, 16'h0000, 16'h0001, 5'h1F, 16'hFFFF);
		rd(`CAS_ADDR_STATUS, 16'h010F, 16'h0008);
		alu(`CAS_OP_ADD, 1'h1, 16'h127F, 16'h0001, 5'h1F, 16'h1280);
		rd(`CAS_ADDR_STATUS, 16'h010F, 16'h010C);
		alu(`CAS_OP_OR, 1'h0, 16'h0F0F, 16'h00FF, 5'h00, 16'h0FFF);
		alu(`CAS_OP_XOR, 1'h0, 16'h0F0F, 16'h00FF, 5'h00, 16'h0FF0);
		alu(`CAS_OP_SHL, 1'h0, 16'h8001, 16'h0000, 5'h01, 16'h0002);
		rd(`CAS_ADDR_STATUS, 16'h0001, 16'h0001);
		alu(`CAS_OP_ASR, 1'h1, 16'h3481, 16'h0000, 5'h09, 16'h34C0);
		rd(`CAS_ADDR_STATUS, 16'h0009, 16'h0009);
		alu(`CAS_OP_SHR, 1'h0, 16'h8002, 16'h0000, 5'h09, 16'h4001);
		rd(`CAS_ADDR_STATUS, 16'h0009, 16'h0000);
		for (k = 0; k < 7; k = k + 1) begin
			@(posedge sys_clk);
			mul_mode <= k[2:0];
			mul_a <= 16'hFFFE;
			mul_b <= 16'hFFE3;
			mul_go <= 1'h1;
			@(posedge sys_clk);
			mul_go <= 1'h0;
			#1 chk("mul", mul_result, mexp[k]);
			chk("mdn", mul_done, 1'h1);
		end
		dv(1'h0, 1'h1, 32'h0001_0005, 16'h0010, 16'h1000, 16'h0005);
		dv(1'h1, 1'h0, 32'hFFFF_FFF9, 16'h0002, 16'hFFFD, 16'hFFFF);
		dv(1'h1, 1'h1, 32'hFFFE_FFED, 16'h0010, 16'hEFFF, 16'hFFFD);
		dv(1'h0, 1'h0, 32'h1234_8001, 16'h0007, 16'h1249, 16'h0002);
		end_sim;
	end
endmodule
